/* design/port2_pkg.sv */
/*
 Constants, register map and carrier types for the port 2 pin function block.
 Assumes a plain register port with one-cycle strobes and read data one cycle later.
*/
// Overview of operation
// RULE1: Mode bit 2 zero gives push-pull serial-out-1 pin; one gives open-drain.
// RULE2: Mode bit 1 zero makes pin 1 general I/O; one makes it count direction.
// RULE3: Mode bit 0 zero makes pin 0 general I/O; one makes it interrupt input.
// RULE4: Eight-bit read/write open-drain select register, one bit per pin, resets to zero.
// RULE5: An output pin drives push-pull when its select bit is zero, else open-drain.
// RULE6: Pins 7 to 2 are inputs on direction bit zero, outputs on one.
// RULE7: Pin 1 follows its direction bit unless count-direction input is selected.
// RULE8: Pin 0 with interrupt select uses trigger enable to add converter trigger role.
// RULE9: Software disables the external interrupt before using pin 0 as converter trigger.
// RULE10: Pins float in reset and standby, hold in sleep modes, work when active.
// RULE11: Port read gives data bit for output pins and pin level for input pins.
// RULE12: Direction and data settings only act while the pin is general I/O.
// RULE13: Direction register is write-only, resets to zero, and reads as all ones.
// RULE14: Register changes reach the pins on the cycle after the write; here the pins change two cycles after the write strobe.
package port2_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_DIR = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam logic [3:0] ADDR_OD = 4'h3;
    localparam logic [3:0] ADDR_TRIG = 4'h4;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DIR_READ = 8'hFF;
    localparam logic [7:0] MODE_RESET = 8'hC0;
    localparam logic [7:0] MODE_RSVD = 8'hC0;
    localparam logic [7:0] OD_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int MODE_SO1_OD_BIT = 2;
    localparam int MODE_COUNT_DIR_BIT = 1;
    localparam int MODE_IRQ_BIT = 0;
    localparam int PIN_COUNT_DIR = 1;
    localparam int PIN_IRQ = 0;

    // ==========================================================
    // Power modes
    typedef enum logic [2:0] {
        PM_ACTIVE, PM_SUBACTIVE, PM_SLEEP, PM_SUBSLEEP, PM_WATCH, PM_STANDBY
    } power_mode_e;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [5:0] mode;
        logic [7:0] od;
        logic trig_en;
    } port_cfg_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;
endpackage

/* design/port2_pin_sync.sv */
/*
 Three-stage pin synchroniser; a change is taken once stages two and three agree.
 Assumes asynchronous pin inputs and one clock.
*/
`timescale 1ns/1ps
module port2_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins
    input wire logic [7:0] pin_raw,
    output logic [7:0] pin_level
);
    logic [7:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [7:0] lvl_next;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            s3_reg <= 8'h00;
            lvl_reg <= 8'h00;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign pin_level = lvl_reg;
endmodule // port2_pin_sync

/* design/port2_pin_function_select.sv */
/*
 Port 2 pin function select: direction, data, mode and open-drain registers,
 pin driver control per power mode, and the serial-out-1 drive type.
 Assumes the power manager supplies the current mode and software keeps the
 external interrupt disabled when pin 0 serves as converter trigger.
*/
`timescale 1ns/1ps
module port2_pin_function_select (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Power mode
    input wire port2_pkg::power_mode_e power_mode,
    // Port pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // Alternate functions
    output logic count_direction_pin,
    output logic external_interrupt_n,
    output logic converter_external_trigger_n,
    // Serial output 1 buffer
    input wire logic serial_out1_data,
    input wire logic serial_out1_active,
    output logic serial_out1_pin_out,
    output logic serial_out1_pin_oe
);
    // ==========================================================
    // Registers
    port2_pkg::port_cfg_s cfg_reg, cfg_next;
    logic [7:0] rdata_reg, rdata_next;
    port2_pkg::pin_drive_s drv_reg, drv_next;
    logic so_out_reg, so_out_next, so_oe_reg, so_oe_next;
    logic [7:0] pin_level;
    logic [7:0] gpio_sel;
    logic [7:0] eff_dir;
    logic freeze, float_all;

    port2_pin_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_raw(pin_in),
        .pin_level(pin_level)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    // ==========================================================
    // Register writes
    always_comb begin
        cfg_next = cfg_reg;
        if (reg_wr) begin
            if (hit(reg_addr, port2_pkg::ADDR_DATA)) begin
                cfg_next.data = reg_wdata;
            end
            if (hit(reg_addr, port2_pkg::ADDR_DIR)) begin
                cfg_next.dir = reg_wdata; // see RULE13
            end
            if (hit(reg_addr, port2_pkg::ADDR_MODE)) begin
                cfg_next.mode = reg_wdata[5:0];
            end
            if (hit(reg_addr, port2_pkg::ADDR_OD)) begin
                cfg_next.od = reg_wdata; // see RULE4
            end
            if (hit(reg_addr, port2_pkg::ADDR_TRIG)) begin
                cfg_next.trig_en = reg_wdata[0];
            end
        end
    end

    // ==========================================================
    // Register reads
    always_comb begin
        rdata_next = port2_pkg::UNMAPPED_READ;
        if (reg_rd) begin
            if (hit(reg_addr, port2_pkg::ADDR_DATA)) begin
                // Output pins return stored data, input pins their level
                rdata_next = (cfg_reg.data & eff_dir) | (pin_level & ~eff_dir); // see RULE11
            end else if (hit(reg_addr, port2_pkg::ADDR_DIR)) begin
                rdata_next = port2_pkg::DIR_READ; // see RULE13
            end else if (hit(reg_addr, port2_pkg::ADDR_MODE)) begin
                rdata_next = port2_pkg::MODE_RSVD | {2'b00, cfg_reg.mode};
            end else if (hit(reg_addr, port2_pkg::ADDR_OD)) begin
                rdata_next = cfg_reg.od; // see RULE4
            end else if (hit(reg_addr, port2_pkg::ADDR_TRIG)) begin
                rdata_next = {7'h00, cfg_reg.trig_en};
            end
        end
    end

    // ==========================================================
    // Pin roles
    always_comb begin
        gpio_sel = 8'hFF;
        gpio_sel[port2_pkg::PIN_COUNT_DIR] = ~cfg_reg.mode[port2_pkg::MODE_COUNT_DIR_BIT]; // see RULE2
        gpio_sel[port2_pkg::PIN_IRQ] = ~cfg_reg.mode[port2_pkg::MODE_IRQ_BIT]; // see RULE3
        // Alternate functions are inputs, so the direction bit is masked
        eff_dir = cfg_reg.dir & gpio_sel; // see RULE6, see RULE7, see RULE8, see RULE12
    end

    always_comb begin
        freeze = (power_mode == port2_pkg::PM_SLEEP) || (power_mode == port2_pkg::PM_SUBSLEEP)
            || (power_mode == port2_pkg::PM_WATCH);
        float_all = (power_mode == port2_pkg::PM_STANDBY);
    end

    // ==========================================================
    // Pin drivers
    always_comb begin
        drv_next = drv_reg;
        so_out_next = so_out_reg;
        so_oe_next = so_oe_reg;
        if (float_all) begin
            drv_next.out = 8'h00; // see RULE10
            drv_next.oe = 8'h00;
            so_out_next = 1'b0;
            so_oe_next = 1'b0;
        end else if (!freeze) begin
            for (int i = 0; i < 8; i++) begin
                drv_next.out[i] = cfg_reg.data[i];
                // Open-drain pins only pull low
                drv_next.oe[i] = eff_dir[i] & (~cfg_reg.od[i] | ~cfg_reg.data[i]); // see RULE5
            end
            so_out_next = serial_out1_data;
            if (cfg_reg.mode[port2_pkg::MODE_SO1_OD_BIT]) begin
                so_oe_next = serial_out1_active & ~serial_out1_data; // see RULE1
            end else begin
                so_oe_next = serial_out1_active; // see RULE1
            end
        end
    end

    // ==========================================================
    // State update
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg.data <= port2_pkg::DATA_RESET;
            cfg_reg.dir <= port2_pkg::DIR_RESET;
            cfg_reg.mode <= port2_pkg::MODE_RESET[5:0];
            cfg_reg.od <= port2_pkg::OD_RESET;
            cfg_reg.trig_en <= 1'b0;
            rdata_reg <= port2_pkg::UNMAPPED_READ;
            drv_reg <= '0; // see RULE10
            so_out_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            drv_reg <= drv_next; // see RULE14
            so_out_reg <= so_out_next;
            so_oe_reg <= so_oe_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign pin_out = drv_reg.out;
    assign pin_oe = drv_reg.oe;
    assign serial_out1_pin_out = so_out_reg;
    assign serial_out1_pin_oe = so_oe_reg;
    assign count_direction_pin = pin_level[port2_pkg::PIN_COUNT_DIR]
        & cfg_reg.mode[port2_pkg::MODE_COUNT_DIR_BIT]; // see RULE2
    // Inactive (high) unless pin 0 has the interrupt role
    assign external_interrupt_n = ~cfg_reg.mode[port2_pkg::MODE_IRQ_BIT]
        | pin_level[port2_pkg::PIN_IRQ]; // see RULE8
    assign converter_external_trigger_n = ~(cfg_reg.mode[port2_pkg::MODE_IRQ_BIT]
        & cfg_reg.trig_en) | pin_level[port2_pkg::PIN_IRQ]; // see RULE8, see RULE9
endmodule // port2_pin_function_select

/* verif/port2_monitor.sv */
/*
 Port 2 pin function checker.
 Bound to the block top in the bench; sees only its ports.
*/
`timescale 1ns/1ps
module port2_monitor (
    // Clock and register port
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and functions
    input wire port2_pkg::power_mode_e power_mode,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic count_direction_pin,
    input wire logic external_interrupt_n,
    input wire logic converter_external_trigger_n,
    input wire logic serial_out1_pin_out,
    input wire logic serial_out1_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Helpers
    logic act;
    logic mw;
    assign act = power_mode == port2_pkg::PM_ACTIVE;
    assign mw = reg_wr && reg_addr == port2_pkg::ADDR_MODE;
    // ==========================================================
    // Assertions
    dir_read_a: assert property (
        $past(reg_rd && reg_addr == port2_pkg::ADDR_DIR) |-> reg_rdata == 8'hFF)
        else $error("direction read not all ones");
    standby_float_a: assert property (
        power_mode == port2_pkg::PM_STANDBY |=> pin_oe == 8'h00)
        else $error("pins driven in standby");
    sleep_hold_a: assert property (
        power_mode inside {port2_pkg::PM_SLEEP, port2_pkg::PM_SUBSLEEP, port2_pkg::PM_WATCH}
        |=> $stable(pin_oe) && $stable(pin_out)) else $error("pins moved in sleep");
    cnt_dir_off_a: assert property (
        mw && !reg_wdata[1] ##1 !mw |=> !count_direction_pin)
        else $error("count direction active as general pin");
    irq_off_a: assert property (
        mw && !reg_wdata[0] ##1 !mw |=> external_interrupt_n && converter_external_trigger_n)
        else $error("interrupt active as general pin");
    alt_input_a: assert property (
        mw && reg_wdata[1:0] == 2'b11 && act ##1 !mw && act |=> pin_oe[1:0] == 2'b00)
        else $error("alternate input pin driven");
    od_pins_a: assert property (
        reg_wr && reg_addr == port2_pkg::ADDR_OD && reg_wdata == 8'hFF && act
        ##1 !reg_wr && act |=> (pin_oe & pin_out) == 8'h00) else $error("open drain drove high");
    so1_od_a: assert property (
        mw && reg_wdata[2] && act ##1 !mw && act |=> !(serial_out1_pin_oe && serial_out1_pin_out))
        else $error("serial out open drain drove high");
    cover property (mw ##2 count_direction_pin);
    cover property (power_mode == port2_pkg::PM_STANDBY);
    cover property (reg_rd && reg_addr == port2_pkg::ADDR_DIR);
endmodule // port2_monitor

/* verif/port2_pin_function_select_test.sv */
/*
 Self-checking bench for the port 2 pin function block.
 Drives all ports itself; the checker is bound at the foot.
*/
`timescale 1ns/1ps
module port2_pin_function_select_test;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
    logic serial_out1_data = 0, serial_out1_active = 0, serial_out1_pin_out, serial_out1_pin_oe;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, pin_in = 8'h00, reg_rdata, pin_out, pin_oe, d, r, o, v;
    logic count_direction_pin, external_interrupt_n, converter_external_trigger_n;
    port2_pkg::power_mode_e power_mode = port2_pkg::PM_ACTIVE;
    int mismatches = 0, check_count = 0, cyc = 0;
    port2_pin_function_select dut_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .power_mode, .pin_in, .pin_out, .pin_oe, .count_direction_pin,
        .external_interrupt_n, .converter_external_trigger_n, .serial_out1_data,
        .serial_out1_active, .serial_out1_pin_out, .serial_out1_pin_oe);
    // ==========================================================
    // Tasks
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] x);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= x;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] x);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 x = reg_rdata;
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] oe_exp(logic [7:0] dr, logic [7:0] od, logic [7:0] dt);
        return dr & (~od | ~dt);
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and tests
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        static logic [3:0] ra[4] = '{4'h3, 4'h1, 4'h2, 4'hF};
        static logic [7:0] rv[4] = '{8'h00, 8'hFF, 8'hC0, 8'h00};
        static port2_pkg::power_mode_e hm[3] = '{port2_pkg::PM_SLEEP, port2_pkg::PM_SUBSLEEP,
            port2_pkg::PM_WATCH};
        void'($urandom(51));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], v);
            chk("reset read", rv[i], v);
        end
        $display("reset values done");
        repeat (16) begin
            d = 8'($urandom);
            o = 8'($urandom);
            r = 8'($urandom);
            wr(4'h0, d);
            pin_in <= 8'($urandom);
            wr(4'h3, o);
            wr(4'h1, r);
            settle();
            chk("oe", oe_exp(r, o, d), pin_oe);
            chk("out", d, pin_out);
            rd(4'h3, v);
            chk("od read", o, v);
            rd(4'h0, v);
            chk("port read", (d & r) | (pin_in & ~r), v);
        end
        // All pins open-drain: only low data bits may drive
        wr(4'h1, 8'hFF);
        wr(4'h3, 8'hFF);
        settle();
        chk("od all", ~d, pin_oe);
        chk("od all out", d, pin_out);
        $display("general pins done");
        wr(4'h3, 8'h00);
        wr(4'h1, 8'hFF);
        pin_in <= 8'h02;
        wr(4'h2, 8'h03);
        settle();
        chk("alt oe", 8'hFC, pin_oe);
        repeat (6) settle();
        chk("alt in", 8'h05, {5'h00, count_direction_pin, external_interrupt_n,
            converter_external_trigger_n});
        wr(4'h4, 8'h01);
        repeat (2) settle();
        chk("trigger", 8'h00, {7'h00, converter_external_trigger_n});
        rd(4'h0, v);
        chk("alt read", (d & 8'hFC) | 8'h02, v);
        wr(4'h2, 8'h00);
        repeat (2) settle();
        chk("general again", 8'hFF, pin_oe);
        chk("no alt", 8'h03, {6'h00, external_interrupt_n, converter_external_trigger_n});
        $display("alternate functions done");
        serial_out1_active <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, {5'h00, i[1], 2'b00});
            serial_out1_data <= i[0];
            repeat (2) settle();
            chk("so1", {6'h00, ~(i[1] & i[0]), i[0]},
                {6'h00, serial_out1_pin_oe, serial_out1_pin_out});
        end
        $display("serial drive done");
        wr(4'h2, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            power_mode <= hm[i];
            wr(4'h1, 8'(i));
            settle();
            chk("hold oe", 8'hFF, pin_oe);
        end
        @(posedge clk);
        power_mode <= port2_pkg::PM_STANDBY;
        repeat (2) settle();
        chk("standby oe", 8'h00, pin_oe);
        @(posedge clk);
        power_mode <= port2_pkg::PM_SUBACTIVE;
        repeat (2) settle();
        chk("subactive oe", 8'h02, pin_oe);
        @(posedge clk);
        arst_n <= 1'b0;
        #1 chk("reset oe", 8'h00, pin_oe);
        chk("reset alt", 8'h03, {5'h00, count_direction_pin, external_interrupt_n,
            converter_external_trigger_n});
        @(posedge clk);
        arst_n <= 1'b1;
        rd(4'h3, v);
        chk("reset od", 8'h00, v);
        chk("reset oe after", 8'h00, pin_oe);
        rd(4'h2, v);
        chk("reset mode", 8'hC0, v);
        $display("power modes done");
        summarize();
    end
endmodule // port2_pin_function_select_test

bind port2_pin_function_select port2_monitor mon_u (.clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .power_mode, .pin_out, .pin_oe, .count_direction_pin,
    .external_interrupt_n, .converter_external_trigger_n, .serial_out1_pin_out,
    .serial_out1_pin_oe);
